/* File: hw/hwmul_cfg.svh */
// constants of the halfword and word multiply unit
// Summary of operation
// - cross multiply takes a low half by b high half, xo 168 signed, 136 unsigned.
// - high halfword multiply takes both high halves, xo 40 signed, 8 unsigned.
// - low halfword multiply takes both low halves, xo 424 signed, 392 unsigned.
// - signed halfword forms multiply two's-complement halves to a 32-bit product.
// - unsigned halfword forms multiply unsigned halves to a 32-bit product.
// - primary 31 with xo 75 forms the signed 64-bit product of both words.
// - primary 31 with xo 11 forms the unsigned 64-bit product of both words.
// - high-word multiplies write the upper 32 bits and drop the lower half.
// - with the record flag set cond_field_zero is updated, else left alone.
// - nonzero reserved bits in high-word forms raise no exception.
`ifndef HWMUL_CFG_SVH
`define HWMUL_CFG_SVH
`define HWMUL_PRI_HALF 6'h04
`define HWMUL_PRI_WORD 6'h1f
`define HWMUL_XO_CHW_S 10'h0a8
`define HWMUL_XO_CHW_U 10'h088
`define HWMUL_XO_HHW_S 10'h028
`define HWMUL_XO_HHW_U 10'h008
`define HWMUL_XO_LHW_S 10'h1a8
`define HWMUL_XO_LHW_U 10'h188
`define HWMUL_XO9_HW_S 9'h04b
`define HWMUL_XO9_HW_U 9'h00b
`define HWMUL_CR_LT 3
`define HWMUL_CR_GT 2
`define HWMUL_CR_EQ 1
`define HWMUL_CR_SO 0
`define HWMUL_CR_RST 4'h0
`endif

/* File: hw/hwmul_pkg.sv */
// types of the halfword and word multiply unit
package hwmul_pkg;
   typedef enum logic [1:0] {HWMUL_HALF_X, HWMUL_HALF_H, HWMUL_HALF_L}
      hwmul_sel_t;
   typedef struct packed {
      logic valid;
      logic [31:0] instr;
      logic [31:0] src_gpr_a;
      logic [31:0] src_gpr_b;
      logic xer_so;
   } hwmul_req_t;
   typedef struct packed {
      logic valid;
      logic illegal;
      logic [4:0] dest;
      logic [31:0] data;
      logic cr_we;
      logic [3:0] cond_field_zero;
   } hwmul_rsp_t;
   typedef struct packed {
      hwmul_rsp_t rsp;
   } hwmul_state_t;
endpackage : hwmul_pkg

/* File: hw/hwmul_mul33.sv */
// signed 33 by 33 multiplier core
`timescale 1ns/1ps
`default_nettype none
module hwmul_mul33 (
   input wire logic [32:0] op_a_in,
   input wire logic [32:0] op_b_in,
   output logic [65:0] prod_out
);
   assign prod_out = 66'($signed(op_a_in) * $signed(op_b_in));
endmodule : hwmul_mul33
`default_nettype wire

/* File: hw/hwmul_unit.sv */
// halfword and word multiply datapath with record update
`timescale 1ns/1ps
`default_nettype none
`include "hwmul_cfg.svh"
module hwmul_unit (
   input wire logic mclk_in,
   input wire logic reset_n_in,
   input wire hwmul_pkg::hwmul_req_t req_in,
   output hwmul_pkg::hwmul_rsp_t rsp_out
);
   hwmul_pkg::hwmul_state_t state_q;
   hwmul_pkg::hwmul_state_t state_d;
   logic [5:0] pri;
   logic [9:0] xo;
   logic rec;
   logic hit;
   logic is_word;
   logic sgn;
   logic [32:0] op_a;
   logic [32:0] op_b;
   logic [65:0] prod;
   logic [31:0] res;

   // extend a 32 bit or 16 bit operand into 33 signed bits
   function automatic logic [32:0] ext33(input logic [31:0] v,
                                         input logic wide, input logic s);
      if (wide) begin
         ext33 = {s & v[31], v};
      end else begin
         ext33 = {{17{s & v[15]}}, v[15:0]};
      end
   endfunction : ext33

   assign pri = req_in.instr[31:26];
   assign xo = req_in.instr[10:1];
   assign rec = req_in.instr[0];

   always_comb begin
      hit = 1'b0;
      is_word = 1'b0;
      sgn = 1'b0;
      op_a = '0;
      op_b = '0;
      if (pri == `HWMUL_PRI_HALF) begin
         hit = 1'b1;
         case (xo)
            `HWMUL_XO_CHW_S, `HWMUL_XO_CHW_U: begin
               op_a = ext33({16'h0000, req_in.src_gpr_a[15:0]}, 1'b0, 1'b0);
               op_b = ext33({16'h0000, req_in.src_gpr_b[31:16]}, 1'b0, 1'b0);
               sgn = (xo == `HWMUL_XO_CHW_S);
            end
            `HWMUL_XO_HHW_S, `HWMUL_XO_HHW_U: begin
               op_a = ext33({16'h0000, req_in.src_gpr_a[31:16]}, 1'b0, 1'b0);
               op_b = ext33({16'h0000, req_in.src_gpr_b[31:16]}, 1'b0, 1'b0);
               sgn = (xo == `HWMUL_XO_HHW_S);
            end
            `HWMUL_XO_LHW_S, `HWMUL_XO_LHW_U: begin
               op_a = ext33({16'h0000, req_in.src_gpr_a[15:0]}, 1'b0, 1'b0);
               op_b = ext33({16'h0000, req_in.src_gpr_b[15:0]}, 1'b0, 1'b0);
               sgn = (xo == `HWMUL_XO_LHW_S);
            end
            default: begin
               hit = 1'b0;
            end
         endcase
         // sign extend halves for signed forms
         // zero extend halves for unsigned forms
         op_a = ext33({16'h0000, op_a[15:0]}, 1'b0, sgn);
         op_b = ext33({16'h0000, op_b[15:0]}, 1'b0, sgn);
      end else if (pri == `HWMUL_PRI_WORD) begin
         case (xo[8:0])
            `HWMUL_XO9_HW_S: begin
               hit = 1'b1;
               sgn = 1'b1;
            end
            `HWMUL_XO9_HW_U: begin
               hit = 1'b1;
               sgn = 1'b0;
            end
            default: begin
               hit = 1'b0;
            end
         endcase
         is_word = hit;
         op_a = ext33(req_in.src_gpr_a, 1'b1, sgn);
         op_b = ext33(req_in.src_gpr_b, 1'b1, sgn);
      end
   end

   hwmul_mul33 u_mul (
      .op_a_in(op_a),
      .op_b_in(op_b),
      .prod_out(prod)
   );

   assign res = is_word ? prod[63:32] : prod[31:0];

   always_comb begin
      state_d = state_q;
      state_d.rsp.valid = req_in.valid;
      state_d.rsp.illegal = req_in.valid & ~hit;
      state_d.rsp.cr_we = 1'b0;
      if (req_in.valid && hit) begin
         state_d.rsp.dest = req_in.instr[25:21];
         state_d.rsp.data = res;
         if (rec) begin
            state_d.rsp.cr_we = 1'b1;
            state_d.rsp.cond_field_zero[`HWMUL_CR_LT] = res[31];
            state_d.rsp.cond_field_zero[`HWMUL_CR_GT] =
               ~res[31] & (res != 32'h00000000);
            state_d.rsp.cond_field_zero[`HWMUL_CR_EQ] = (res == 32'h00000000);
            state_d.rsp.cond_field_zero[`HWMUL_CR_SO] = req_in.xer_so;
         end
      end
   end

   always_ff @(posedge mclk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         state_q.rsp.valid <= 1'b0;
         state_q.rsp.illegal <= 1'b0;
         state_q.rsp.dest <= 5'h00;
         state_q.rsp.data <= 32'h00000000;
         state_q.rsp.cr_we <= 1'b0;
         state_q.rsp.cond_field_zero <= `HWMUL_CR_RST;
      end else begin
         state_q <= state_d;
      end
   end

   assign rsp_out = state_q.rsp;
endmodule : hwmul_unit
`default_nettype wire

/* File: testbench/hwmul_far.sv */
// issue side model driving multiply requests
`timescale 1ns/1ps
`default_nettype none
module hwmul_far (
   input wire logic mclk_in,
   output hwmul_pkg::hwmul_req_t req_out
);
   initial req_out = '0;
   task put(input logic [31:0] i, a, b, input logic so);
      @(negedge mclk_in);
      req_out = {1'b1, i, a, b, so};
   endtask : put
   // idle lines carry the inverse of the last request
   task idle();
      req_out = {1'b0, ~req_out[96:0]};
   endtask : idle
endmodule : hwmul_far
`default_nettype wire

/* File: testbench/hwmul_monitor.sv */
// assertions on the multiply unit ports
`timescale 1ns/1ps
`default_nettype none
module hwmul_chk (
   input wire logic mclk_in,
   input wire logic reset_n_in,
   input wire hwmul_pkg::hwmul_req_t req_in,
   input wire hwmul_pkg::hwmul_rsp_t rsp_out
);
   logic [63:0] pu;
   assign pu = {32'h0, req_in.src_gpr_a} * {32'h0, req_in.src_gpr_b};
   logic signed [63:0] ps;
   assign ps = $signed(req_in.src_gpr_a) * $signed(req_in.src_gpr_b);
   default clocking dc @(posedge mclk_in); endclocking
   default disable iff (!reset_n_in);
   resp_next_a: assert property (req_in.valid |=> rsp_out.valid)
      else $error("no answer");
   no_spur_a: assert property (!req_in.valid |=> !rsp_out.valid)
      else $error("stray answer");
   norec_a: assert property (req_in.valid && !req_in.instr[0]
      |=> !rsp_out.cr_we) else $error("flags written");
   dest_map_a: assert property (rsp_out.valid && !rsp_out.illegal
      |-> rsp_out.dest == $past(req_in.instr[25:21])) else $error("dest");
   eq_flag_a: assert property (rsp_out.cr_we
      |-> rsp_out.cond_field_zero[1] == (rsp_out.data == 32'h0))
      else $error("eq flag");
   sign_flag_a: assert property (rsp_out.cr_we |->
      rsp_out.cond_field_zero[3:2] == {rsp_out.data[31],
      !rsp_out.data[31] && |rsp_out.data}) else $error("lt gt");
   so_copy_a: assert property (rsp_out.cr_we
      |-> rsp_out.cond_field_zero[0] == $past(req_in.xer_so))
      else $error("so flag");
   hi_word_a: assert property (req_in.valid &&
      req_in.instr[31:26] == 6'h1f && req_in.instr[9:1] == 9'h00b
      |=> rsp_out.data == $past(pu[63:32])) else $error("high word");
   hi_sword_a: assert property (req_in.valid &&
      req_in.instr[31:26] == 6'h1f && req_in.instr[9:1] == 9'h04b
      |=> rsp_out.data == $past(ps[63:32])) else $error("signed high word");
endmodule : hwmul_chk
`default_nettype wire

/* File: testbench/tb.sv */
// top bench for the multiply unit
`timescale 1ns/1ps
`default_nettype none
`define CK(g,e) begin n_compared++; if ((g) !== (e)) begin n_fail++; \
$display("ERROR %0t %h %h", $time, g, e); end end
module tb;
   logic mclk_in = 1'b0;
   logic reset_n_in = 1'b0;
   hwmul_pkg::hwmul_req_t req;
   hwmul_pkg::hwmul_rsp_t rsp;
   int n_fail = 0;
   int n_compared = 0;
   always #20 mclk_in = ~mclk_in;
   hwmul_far hwmul_far_inst (.mclk_in(mclk_in), .req_out(req));
   hwmul_unit hwmul_unit_inst (.mclk_in(mclk_in), .reset_n_in(reset_n_in),
      .req_in(req), .rsp_out(rsp));
   task chk(input logic il, cw, input logic [31:0] e, input logic so);
      `CK(rsp.valid, 1'b1)
      `CK(rsp.illegal, il)
      `CK(rsp.cr_we, cw)
      if (!il) `CK(rsp.data, e)
      if (cw) `CK(rsp.cond_field_zero, {e[31], !e[31] && |e, ~|e, so})
   endtask : chk
   task op(input logic [31:0] i, a, b, input logic so);
      hwmul_far_inst.put(i, a, b, so);
      @(negedge mclk_in);
      hwmul_far_inst.idle();
   endtask : op
   task t_half();
      logic [9:0] xo [6] = '{10'h0a8, 10'h088, 10'h028, 10'h008, 10'h1a8,
         10'h188};
      logic [15:0] ha, hb;
      logic [31:0] a, b, e;
      a = 32'h8003_fffe;
      b = 32'hfffd_7fff;
      for (int k = 0; k < 6; k++) begin
         ha = (k / 2 == 1) ? a[31:16] : a[15:0];
         hb = (k / 2 == 2) ? b[15:0] : b[31:16];
         if (k[0]) e = ha * hb;
         else e = $signed(ha) * $signed(hb);
         op({6'h04, 5'd7, 5'd1, 5'd2, xo[k], 1'b1}, a, b, k[0]);
         chk(1'b0, 1'b1, e, k[0]);
         `CK(rsp.dest, 5'd7)
      end
   endtask : t_half
   task t_word();
      op({6'h1f, 5'd9, 5'd1, 5'd2, 1'b1, 9'h04b, 1'b0}, 32'hffff_fffe, 32'h3,
         1'b0);
      chk(1'b0, 1'b0, 32'hffff_ffff, 1'b0);
      op({6'h1f, 5'd9, 5'd1, 5'd2, 1'b0, 9'h00b, 1'b1}, 32'hffff_fffe, 32'h3,
         1'b0);
      chk(1'b0, 1'b1, 32'h2, 1'b0);
   endtask : t_word
   task t_b2b();
      hwmul_far_inst.put({6'h1f, 5'd4, 5'd1, 5'd2, 10'h0eb, 1'b1}, 32'h5,
         32'h6, 1'b0);
      hwmul_far_inst.put({6'h04, 5'd5, 5'd1, 5'd2, 10'h0a8, 1'b1}, 32'h0,
         32'h1234_5678, 1'b1);
      chk(1'b1, 1'b0, 32'h0, 1'b0);
      @(negedge mclk_in);
      hwmul_far_inst.idle();
      chk(1'b0, 1'b1, 32'h0, 1'b1);
   endtask : t_b2b
   task t_reset();
      hwmul_far_inst.put({6'h04, 5'd3, 5'd1, 5'd2, 10'h028, 1'b1}, 32'h1,
         32'h1, 1'b1);
      @(negedge mclk_in);
      reset_n_in = 1'b0;
      hwmul_far_inst.idle();
      #1;
      `CK(rsp, 72'h0)
      repeat (2) @(negedge mclk_in);
      reset_n_in = 1'b1;
      op({6'h04, 5'd3, 5'd1, 5'd2, 10'h028, 1'b0}, 32'h0002_0000,
         32'h0003_0000, 1'b0);
      chk(1'b0, 1'b0, 32'h6, 1'b0);
   endtask : t_reset
   task print_verdict();
      $display("compared %0d failed %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : print_verdict
   initial begin
      repeat (6) @(negedge mclk_in);
      reset_n_in = 1'b1;
      t_half();
      t_word();
      t_b2b();
      t_reset();
      print_verdict();
   end
   initial begin
      #20000;
      n_fail++;
      print_verdict();
   end
endmodule : tb
bind hwmul_unit hwmul_chk hwmul_chk_inst (.mclk_in(mclk_in),
   .reset_n_in(reset_n_in), .req_in(req_in), .rsp_out(rsp_out));
`default_nettype wire
